// >>> core/etc_timer.sv
`default_nettype none

module etc_timer (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        external_count_pin,
  input  wire logic        irq_ack_overflow,
  input  wire logic        irq_ack_match_a,
  input  wire logic        irq_ack_match_b,
  output logic             irq_overflow,
  output logic             irq_match_a,
  output logic             irq_match_b,
  output var  logic        compare_a_output,
  output logic             compare_a_output_en,
  output var  logic        compare_b_output,
  output logic             compare_b_output_en
);

  ////////////////////////////////////////////////////////////////////////////

  // Next state of a compare output for a given action and mode kind.
  function automatic logic etc_oc_next(
    input logic                  oc,
    input logic [1:0]            com,
    input etc_pkg::etc_kind_type kind,
    input logic                  match,
    input logic                  restart,
    input logic                  down
  );
    logic res;
    res = oc;
    if (kind == etc_pkg::etc_normal || kind == etc_pkg::etc_ctc) begin
      if (match) begin
        case (com)
          etc_pkg::COM_TOGGLE: res = ~oc;
          etc_pkg::COM_CLEAR:  res = 1'b0;
          etc_pkg::COM_SET:    res = 1'b1;
          default:             res = oc;
        endcase
      end
    end else if (kind == etc_pkg::etc_fast) begin
      if (com[1] && match) begin
        res = com[0];
      end else if (com[1] && restart) begin
        res = ~com[0];
      end
    end else begin
      if (com[1] && match) begin
        res = com[0] ^ down;
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  logic [7:0]  counter_value;
  logic [7:0]  compare_a_value;
  logic [7:0]  compare_b_value;
  logic [7:0]  active_a;
  logic [7:0]  active_b;
  logic [2:0]  waveform_mode_field;
  logic [2:0]  clock_select_field;
  logic [1:0]  com_a;
  logic [1:0]  com_b;
  logic [2:0]  timer_irq_flags;
  logic [2:0]  timer_irq_mask;
  logic        count_down;
  logic        block_match;
  logic        served;
  logic [9:0]  prescale;
  logic        ext_prev;

  logic                  bus_req;
  logic                  bus_wr;
  logic                  wr_byte;
  logic [7:0]            wdata;
  etc_pkg::etc_kind_type kind;
  logic                  pwm;
  logic                  timer_tick_clock;
  logic [7:0]            ceiling;
  logic                  at_floor;
  logic                  at_ceiling;
  logic                  at_max;
  logic                  clear;
  logic [7:0]            next_counter;
  logic                  next_down;
  logic                  match_a;
  logic                  match_b;
  logic                  set_ovf;
  logic                  sync_point;
  logic                  force_a;
  logic                  force_b;
  logic [2:0]            clr_flags;
  logic [2:0]            set_flags;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state on every access.

  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~served;
  assign bus_wr          = avs_write & served;
  assign wr_byte         = bus_wr & avs_byteenable[0];
  assign wdata           = avs_writedata[7:0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      served <= 1'b0;
    end else begin
      served <= bus_req & ~served;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_readdata <= 32'h0000_0000;
      case (avs_address)
        etc_pkg::ADDR_COUNTER:   avs_readdata[7:0] <= counter_value;
        etc_pkg::ADDR_COMPARE_A: avs_readdata[7:0] <= compare_a_value;
        etc_pkg::ADDR_COMPARE_B: avs_readdata[7:0] <= compare_b_value;
        etc_pkg::ADDR_CONTROL_A: begin
          avs_readdata[etc_pkg::CTLA_WGM0_POS]  <= waveform_mode_field[0];
          avs_readdata[etc_pkg::CTLA_WGM1_POS]  <= waveform_mode_field[1];
          avs_readdata[etc_pkg::CTLA_COM_B_POS +: 2] <= com_b;
          avs_readdata[etc_pkg::CTLA_COM_A_POS +: 2] <= com_a;
        end
        etc_pkg::ADDR_CONTROL_B: begin
          avs_readdata[etc_pkg::CTLB_CS_POS +: 3] <= clock_select_field;
          avs_readdata[etc_pkg::CTLB_WGM2_POS]    <= waveform_mode_field[2];
        end
        etc_pkg::ADDR_IRQ_MASK:  avs_readdata[2:0] <= timer_irq_mask;
        etc_pkg::ADDR_IRQ_FLAGS: avs_readdata[2:0] <= timer_irq_flags;
        default:                 avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge clk) begin
    if (!rstn) begin
      waveform_mode_field <= 3'h0;
      clock_select_field  <= etc_pkg::CS_STOP;
      com_a               <= etc_pkg::COM_OFF;
      com_b               <= etc_pkg::COM_OFF;
      timer_irq_mask      <= etc_pkg::RESET_FLAGS;
    end else if (wr_byte) begin
      case (avs_address)
        etc_pkg::ADDR_CONTROL_A: begin
          waveform_mode_field[0] <= wdata[etc_pkg::CTLA_WGM0_POS];
          waveform_mode_field[1] <= wdata[etc_pkg::CTLA_WGM1_POS];
          com_b <= wdata[etc_pkg::CTLA_COM_B_POS +: 2];
          com_a <= wdata[etc_pkg::CTLA_COM_A_POS +: 2];
        end
        etc_pkg::ADDR_CONTROL_B: begin
          clock_select_field     <= wdata[etc_pkg::CTLB_CS_POS +: 3];
          waveform_mode_field[2] <= wdata[etc_pkg::CTLB_WGM2_POS];
        end
        etc_pkg::ADDR_IRQ_MASK: timer_irq_mask <= wdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Force strobes act only in the non-PWM modes and never set a flag.
  assign force_a = wr_byte && avs_address == etc_pkg::ADDR_CONTROL_B &&
                   wdata[etc_pkg::CTLB_FORCE_A_POS] && !pwm;
  assign force_b = wr_byte && avs_address == etc_pkg::ADDR_CONTROL_B &&
                   wdata[etc_pkg::CTLB_FORCE_B_POS] && !pwm;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode; the unused codes 4 and 6 count like normal mode.

  always_comb begin
    case (waveform_mode_field)
      3'h1, 3'h5: kind = etc_pkg::etc_phase;
      3'h2:       kind = etc_pkg::etc_ctc;
      3'h3, 3'h7: kind = etc_pkg::etc_fast;
      default:    kind = etc_pkg::etc_normal;
    endcase
  end

  assign pwm = kind == etc_pkg::etc_fast || kind == etc_pkg::etc_phase;

  always_comb begin
    if (kind == etc_pkg::etc_ctc || (pwm && waveform_mode_field[2])) begin
      ceiling = active_a;
    end else begin
      ceiling = etc_pkg::COUNT_MAX;
    end
  end

  assign at_floor   = counter_value == etc_pkg::COUNT_BOTTOM;
  assign at_max     = counter_value == etc_pkg::COUNT_MAX;
  assign at_ceiling = counter_value == ceiling;

  ////////////////////////////////////////////////////////////////////////////
  // Clock select: prescaled system clock or count pin edges.

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prescale <= 10'h000;
      ext_prev <= 1'b0;
    end else begin
      prescale <= prescale + 10'h001;
      ext_prev <= external_count_pin;
    end
  end

  always_comb begin
    case (clock_select_field)
      etc_pkg::CS_DIV1:     timer_tick_clock = 1'b1;
      etc_pkg::CS_DIV8:     timer_tick_clock = &prescale[2:0];
      etc_pkg::CS_DIV64:    timer_tick_clock = &prescale[5:0];
      etc_pkg::CS_DIV256:   timer_tick_clock = &prescale[7:0];
      etc_pkg::CS_DIV1024:  timer_tick_clock = &prescale;
      etc_pkg::CS_EXT_FALL: timer_tick_clock = ext_prev & ~external_count_pin;
      etc_pkg::CS_EXT_RISE: timer_tick_clock = ~ext_prev & external_count_pin;
      default:              timer_tick_clock = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter unit.

  assign clear = (kind == etc_pkg::etc_ctc || kind == etc_pkg::etc_fast) &&
                 at_ceiling;

  always_comb begin
    next_down = count_down;
    if (kind == etc_pkg::etc_phase) begin
      if (!count_down && at_ceiling) begin
        next_down = 1'b1;
      end else if (count_down && at_floor) begin
        next_down = 1'b0;
      end
    end else begin
      next_down = 1'b0;
    end
    if (clear) begin
      next_counter = etc_pkg::COUNT_BOTTOM;
    end else if (next_down) begin
      next_counter = counter_value - 8'h01;
    end else begin
      next_counter = counter_value + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      counter_value <= etc_pkg::RESET_BYTE;
    end else if (wr_byte && avs_address == etc_pkg::ADDR_COUNTER) begin
      counter_value <= wdata;
    end else if (timer_tick_clock) begin
      counter_value <= next_counter;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_down <= 1'b0;
    end else if (timer_tick_clock) begin
      count_down <= next_down;
    end
  end

  // A counter write arms a block that swallows the matches of the next tick.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      block_match <= 1'b0;
    end else if (wr_byte && avs_address == etc_pkg::ADDR_COUNTER) begin
      block_match <= 1'b1;
    end else if (timer_tick_clock) begin
      block_match <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare units with double buffering in the PWM modes.

  assign sync_point = timer_tick_clock && at_ceiling;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      compare_a_value <= etc_pkg::RESET_BYTE;
      compare_b_value <= etc_pkg::RESET_BYTE;
    end else if (wr_byte && avs_address == etc_pkg::ADDR_COMPARE_A) begin
      compare_a_value <= wdata;
    end else if (wr_byte && avs_address == etc_pkg::ADDR_COMPARE_B) begin
      compare_b_value <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      active_a <= etc_pkg::RESET_BYTE;
      active_b <= etc_pkg::RESET_BYTE;
    end else if (!pwm || sync_point) begin
      active_a <= compare_a_value;
      active_b <= compare_b_value;
    end
  end

  // The tick that moves the counter away from a matching value sets the flag.
  assign match_a = timer_tick_clock && !block_match &&
                   counter_value == active_a;
  assign match_b = timer_tick_clock && !block_match &&
                   counter_value == active_b;

  always_comb begin
    case (kind)
      etc_pkg::etc_fast:  set_ovf = timer_tick_clock && at_ceiling;
      etc_pkg::etc_phase: set_ovf = timer_tick_clock && count_down && at_floor;
      default:            set_ovf = timer_tick_clock && at_max;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: a set in the same cycle as a clear wins.

  always_comb begin
    clr_flags = {irq_ack_match_b, irq_ack_match_a, irq_ack_overflow};
    if (wr_byte && avs_address == etc_pkg::ADDR_IRQ_FLAGS) begin
      clr_flags = clr_flags | wdata[2:0];
    end
    set_flags = 3'h0;
    set_flags[etc_pkg::IRQ_OVF_POS]     = set_ovf;
    set_flags[etc_pkg::IRQ_MATCH_A_POS] = match_a;
    set_flags[etc_pkg::IRQ_MATCH_B_POS] = match_b;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      timer_irq_flags <= etc_pkg::RESET_FLAGS;
    end else begin
      timer_irq_flags <= (timer_irq_flags & ~clr_flags) | set_flags;
    end
  end

  assign irq_overflow = timer_irq_flags[etc_pkg::IRQ_OVF_POS] &
                        timer_irq_mask[etc_pkg::IRQ_OVF_POS];
  assign irq_match_a  = timer_irq_flags[etc_pkg::IRQ_MATCH_A_POS] &
                        timer_irq_mask[etc_pkg::IRQ_MATCH_A_POS];
  assign irq_match_b  = timer_irq_flags[etc_pkg::IRQ_MATCH_B_POS] &
                        timer_irq_mask[etc_pkg::IRQ_MATCH_B_POS];

  ////////////////////////////////////////////////////////////////////////////
  // Waveform outputs.

  always_ff @(posedge clk) begin
    if (!rstn) begin
      compare_a_output <= 1'b0;
      compare_b_output <= 1'b0;
    end else begin
      compare_a_output <= etc_oc_next(compare_a_output, com_a, kind,
                                      match_a | force_a, sync_point,
                                      count_down);
      compare_b_output <= etc_oc_next(compare_b_output, com_b, kind,
                                      match_b | force_b, sync_point,
                                      count_down);
    end
  end

  assign compare_a_output_en = com_a != etc_pkg::COM_OFF;
  assign compare_b_output_en = com_b != etc_pkg::COM_OFF;

endmodule // etc_timer

`default_nettype wire

// >>> inc/etc_pkg.sv
`default_nettype none

package etc_pkg;

  // Byte addresses of the register words on the Avalon-MM slave.
  localparam logic [4:0] ADDR_COUNTER   = 5'h00;
  localparam logic [4:0] ADDR_COMPARE_A = 5'h04;
  localparam logic [4:0] ADDR_COMPARE_B = 5'h08;
  localparam logic [4:0] ADDR_CONTROL_A = 5'h0C;
  localparam logic [4:0] ADDR_CONTROL_B = 5'h10;
  localparam logic [4:0] ADDR_IRQ_MASK  = 5'h14;
  localparam logic [4:0] ADDR_IRQ_FLAGS = 5'h18;

  // Field positions in timer_control_a.
  localparam int CTLA_WGM0_POS   = 0;
  localparam int CTLA_WGM1_POS   = 1;
  localparam int CTLA_COM_B_POS  = 4;
  localparam int CTLA_COM_A_POS  = 6;

  // Field positions in timer_control_b.
  localparam int CTLB_CS_POS     = 0;
  localparam int CTLB_WGM2_POS   = 3;
  localparam int CTLB_FORCE_B_POS = 6;
  localparam int CTLB_FORCE_A_POS = 7;

  // Bit positions in timer_irq_flags and timer_irq_mask.
  localparam int IRQ_OVF_POS     = 0;
  localparam int IRQ_MATCH_A_POS = 1;
  localparam int IRQ_MATCH_B_POS = 2;

  // Reset values.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_FLAGS = 3'h0;

  // Counter extremes.
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hFF;

  // Clock select codes.
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Compare output actions.
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  typedef enum logic [1:0] {
    etc_normal,
    etc_ctc,
    etc_fast,
    etc_phase
  } etc_kind_type;

endpackage : etc_pkg

`default_nettype wire

// >>> verification/eight_bit_timer_counter_bench.sv
`default_nettype none

module eight_bit_timer_counter_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        external_count_pin, ack_o, ack_a, ack_b;
  logic        irq_o, irq_a, irq_b, out_a, out_a_en, out_b, out_b_en;
  int          n_fail, n_tests, cycles;

  etc_timer u_dut (
    .clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_count_pin(external_count_pin), .irq_ack_overflow(ack_o),
    .irq_ack_match_a(ack_a), .irq_ack_match_b(ack_b),
    .irq_overflow(irq_o), .irq_match_a(irq_a), .irq_match_b(irq_b),
    .compare_a_output(out_a), .compare_a_output_en(out_a_en),
    .compare_b_output(out_b), .compare_b_output_en(out_b_en)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic fail(input string m);
    n_fail++;
    $display("ERROR %0t %s", $time, m);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
  endtask

  // One Avalon access; holds the request until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {24'h00_0000, d};
    // Values read just after an edge are those the design held at it.
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic pulse();
    external_count_pin <= 1'b1;
    repeat (4) @(posedge clk);
    external_count_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 8; i++) rd(5'(i * 4), 8'h00);
    $display("reset values done");
  endtask

  task automatic t_stop();
    wr(etc_pkg::ADDR_COUNTER, 8'h5A);
    repeat (10) @(posedge clk);
    rd(etc_pkg::ADDR_COUNTER, 8'h5A);
    $display("stopped counter done");
  endtask

  task automatic t_ovf();
    wr(etc_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(etc_pkg::ADDR_COUNTER, 8'hFE);
    wr(etc_pkg::ADDR_CONTROL_B, {5'h00, etc_pkg::CS_EXT_RISE});
    pulse();
    rd(etc_pkg::ADDR_IRQ_FLAGS, 8'h00);
    pulse();
    rd(etc_pkg::ADDR_COUNTER, 8'h00);
    rd(etc_pkg::ADDR_IRQ_FLAGS, 8'h01);
    chk({7'h00, irq_o}, 8'h01);
    wr(etc_pkg::ADDR_IRQ_MASK, 8'h00);
    @(posedge clk);
    chk({7'h00, irq_o}, 8'h00);
    wr(etc_pkg::ADDR_IRQ_FLAGS, 8'h01);
    rd(etc_pkg::ADDR_IRQ_FLAGS, 8'h00);
    $display("overflow done");
  endtask

  task automatic t_match();
    wr(etc_pkg::ADDR_CONTROL_B, 8'h00);
    wr(etc_pkg::ADDR_COMPARE_A, 8'h10);
    wr(etc_pkg::ADDR_COMPARE_B, 8'h11);
    wr(etc_pkg::ADDR_COUNTER, 8'h10);
    wr(etc_pkg::ADDR_CONTROL_B, {5'h00, etc_pkg::CS_EXT_RISE});
    pulse();
    rd(etc_pkg::ADDR_IRQ_FLAGS, 8'h00);
    wr(etc_pkg::ADDR_COUNTER, 8'h0F);
    pulse();
    rd(etc_pkg::ADDR_IRQ_FLAGS, 8'h00);
    pulse();
    rd(etc_pkg::ADDR_IRQ_FLAGS, 8'h02);
    pulse();
    rd(etc_pkg::ADDR_IRQ_FLAGS, 8'h06);
    wr(etc_pkg::ADDR_CONTROL_B, 8'h00);
    wr(etc_pkg::ADDR_IRQ_MASK, 8'h06);
    @(posedge clk);
    chk({6'h00, irq_b, irq_a}, 8'h03);
    wr(etc_pkg::ADDR_IRQ_FLAGS, 8'h04);
    rd(etc_pkg::ADDR_IRQ_FLAGS, 8'h02);
    ack_a <= 1'b1;
    @(posedge clk);
    ack_a <= 1'b0;
    rd(etc_pkg::ADDR_IRQ_FLAGS, 8'h00);
    $display("compare match done");
  endtask

  task automatic t_ctc();
    wr(etc_pkg::ADDR_CONTROL_A, 8'h42);
    wr(etc_pkg::ADDR_COMPARE_A, 8'h03);
    wr(etc_pkg::ADDR_COUNTER, 8'h00);
    wr(etc_pkg::ADDR_CONTROL_B, {5'h00, etc_pkg::CS_EXT_RISE});
    repeat (3) pulse();
    rd(etc_pkg::ADDR_COUNTER, 8'h03);
    pulse();
    rd(etc_pkg::ADDR_COUNTER, 8'h00);
    chk({6'h00, out_a_en, out_a}, 8'h03);
    wr(etc_pkg::ADDR_CONTROL_B, 8'h87);
    repeat (2) @(posedge clk);
    chk({7'h00, out_a}, 8'h00);
    chk({6'h00, out_b_en, out_b}, 8'h00);
    $display("clear on compare done");
  endtask

  task automatic t_phase();
    wr(etc_pkg::ADDR_CONTROL_B, 8'h00);
    wr(etc_pkg::ADDR_CONTROL_A, 8'h01);
    wr(etc_pkg::ADDR_COUNTER, 8'hFE);
    wr(etc_pkg::ADDR_CONTROL_B, {5'h00, etc_pkg::CS_EXT_FALL});
    external_count_pin <= 1'b1;
    repeat (4) @(posedge clk);
    rd(etc_pkg::ADDR_COUNTER, 8'hFE);
    external_count_pin <= 1'b0;
    repeat (4) @(posedge clk);
    rd(etc_pkg::ADDR_COUNTER, 8'hFF);
    pulse();
    rd(etc_pkg::ADDR_COUNTER, 8'hFE);
    $display("phase count done");
  endtask

  // Fast mode with the ceiling taken from compare A, which holds 0x03.
  task automatic t_fast();
    wr(etc_pkg::ADDR_CONTROL_B, 8'h00);
    wr(etc_pkg::ADDR_CONTROL_A, 8'h03);
    wr(etc_pkg::ADDR_IRQ_FLAGS, 8'h07);
    wr(etc_pkg::ADDR_COUNTER, 8'h00);
    wr(etc_pkg::ADDR_CONTROL_B, 8'h0F);
    rd(etc_pkg::ADDR_CONTROL_B, 8'h0F);
    repeat (3) pulse();
    rd(etc_pkg::ADDR_COUNTER, 8'h03);
    rd(etc_pkg::ADDR_IRQ_FLAGS, 8'h00);
    pulse();
    rd(etc_pkg::ADDR_COUNTER, 8'h00);
    rd(etc_pkg::ADDR_IRQ_FLAGS, 8'h03);
    ack_o <= 1'b1;
    @(posedge clk);
    ack_o <= 1'b0;
    rd(etc_pkg::ADDR_IRQ_FLAGS, 8'h02);
    $display("fast count done");
  endtask

  task automatic t_reset2();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(etc_pkg::ADDR_COUNTER, 8'h00);
    rd(etc_pkg::ADDR_CONTROL_A, 8'h00);
    $display("second reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail("timeout");
      give_verdict();
    end
  end

  initial begin
    n_fail = 0;
    n_tests = 0;
    cycles = 0;
    rstn = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    external_count_pin = 1'b0;
    ack_o = 1'b0;
    ack_a = 1'b0;
    ack_b = 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_stop();
    t_ovf();
    t_match();
    t_ctc();
    t_phase();
    t_fast();
    t_reset2();
    give_verdict();
  end
endmodule // eight_bit_timer_counter_bench

`default_nettype wire

// >>> verification/etc_timer_assertions.sv
`default_nettype none

module etc_timer_checker (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        irq_ack_match_a,
  input wire logic        irq_overflow,
  input wire logic        irq_match_a,
  input wire logic        irq_match_b,
  input wire logic        compare_a_output,
  input wire logic        compare_b_output,
  input wire logic        compare_a_output_en,
  input wire logic        compare_b_output_en
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       wr_ok;
  logic [2:0] mask_sh;
  logic [2:0] cs_sh;
  logic [3:0] com_sh;

  // Shadows of the mask, clock select and output action fields.
  assign wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0];

  always_ff @(posedge clk) begin
    if (!rstn) mask_sh <= 3'h0;
    else if (wr_ok && avs_address == etc_pkg::ADDR_IRQ_MASK)
      mask_sh <= avs_writedata[2:0];
  end

  always_ff @(posedge clk) begin
    if (!rstn) cs_sh <= 3'h0;
    else if (wr_ok && avs_address == etc_pkg::ADDR_CONTROL_B)
      cs_sh <= avs_writedata[2:0];
  end

  always_ff @(posedge clk) begin
    if (!rstn) com_sh <= 4'h0;
    else if (wr_ok && avs_address == etc_pkg::ADDR_CONTROL_A)
      com_sh <= avs_writedata[7:4];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
  idle_nowait_a: assert property (!(avs_read || avs_write)
    |-> !avs_waitrequest) else $error("wait without request");
  read_upper_a: assert property (avs_read && !avs_waitrequest
    |-> avs_readdata[31:8] == 24'h00_0000) else $error("upper bits set");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest
    && avs_address == 5'h1C |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  irq_masked_a: assert property (({irq_match_b, irq_match_a,
    irq_overflow} & ~mask_sh) == 3'h0) else $error("masked irq high");
  reset_quiet_a: assert property (@(posedge clk) disable iff (1'b0)
    !rstn |=> !irq_overflow && !irq_match_a && !irq_match_b
    && !compare_a_output && !compare_b_output && !compare_a_output_en
    && !compare_b_output_en) else $error("state after reset");
  stop_noflag_a: assert property (cs_sh == 3'h0
    && $past(cs_sh) == 3'h0 && $stable(mask_sh)
    |-> !$rose(irq_overflow) && !$rose(irq_match_a) && !$rose(irq_match_b))
    else $error("flag rose while stopped");
  ack_clear_a: assert property (irq_ack_match_a && cs_sh == 3'h0
    |=> !irq_match_a) else $error("ack did not clear");
  wr1_clear_a: assert property (wr_ok && cs_sh == 3'h0
    && avs_address == etc_pkg::ADDR_IRQ_FLAGS && avs_writedata[2]
    |=> !irq_match_b) else $error("write one did not clear");
  enable_pins_a: assert property (compare_a_output_en
    == (com_sh[3:2] != 2'h0) && compare_b_output_en == (com_sh[1:0] != 2'h0))
    else $error("output enable wrong");

  cover property ($rose(irq_overflow));
  cover property ($rose(irq_match_a));
  cover property ($rose(compare_a_output));
endmodule // etc_timer_checker

bind etc_timer etc_timer_checker u_chk (
  .clk(clk), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq_ack_match_a(irq_ack_match_a), .irq_overflow(irq_overflow),
  .irq_match_a(irq_match_a), .irq_match_b(irq_match_b),
  .compare_a_output(compare_a_output), .compare_b_output(compare_b_output),
  .compare_a_output_en(compare_a_output_en),
  .compare_b_output_en(compare_b_output_en)
);

`default_nettype wire
